// *** rtl/acqfp_pkg.sv ***
/*
 Types of the acquire-mode front panel control block.
 Assumes no surroundings; used by scoped names only.
*/
package acqfp_pkg;
   typedef enum logic [1:0] {
      ACQFP_CH1 = 2'b00,
      ACQFP_CH2 = 2'b01,
      ACQFP_BOTH = 2'b10,
      ACQFP_ADD = 2'b11
   } acqfp_mode_t;
   typedef enum logic [1:0] {
      ACQFP_DIG_ROLL = 2'b00,
      ACQFP_DIG_RT = 2'b01,
      ACQFP_DIG_ERD = 2'b10,
      ACQFP_DIG_EQT = 2'b11
   } acqfp_dig_t;
   // Key pulses after synchronisation
   typedef struct packed {
      logic ch1;
      logic ch2;
      logic both;
      logic add;
      logic freeze;
      logic shift;
      logic avg_n;
      logic env;
      logic envelope_n_acquire;
      logic hold_next;
      logic alt_key;
      logic plain_key;
      logic cw;
      logic ccw;
   } acqfp_keys_t;
   // Acquisition path enables
   typedef struct packed {
      logic dig1;
      logic dig2;
      logic sum;
      logic inv2;
      logic wr1;
      logic wr2;
      logic disp1;
      logic disp2;
   } acqfp_path_t;
endpackage

// *** rtl/acqfp_regs.svh ***
/*
 Constants of the acquire-mode front panel control block.
 Assumes inclusion by bare name; definitions only.
*/
`ifndef ACQFP_REGS_SVH
`define ACQFP_REGS_SVH
// Register byte offsets
`define ACQFP_CTRL_OFS 12'h000
`define ACQFP_STAT_OFS 12'h004
`define ACQFP_SWEEP_OFS 12'h008
// Control register field positions
`define ACQFP_CTRL_INV_BIT 0
// Status register field positions
`define ACQFP_STAT_MODE_LSB 0
`define ACQFP_STAT_FRZ_BIT 2
`define ACQFP_STAT_SHIFT_BIT 3
`define ACQFP_STAT_CSW_BIT 4
`define ACQFP_STAT_DIG_LSB 5
// Sweep index range: 0 external clock, 1 is 20 s/div, 27 is 50 ns/div
`define ACQFP_SWEEP_EXT 5'h00
`define ACQFP_SWEEP_SLOW 5'h01
`define ACQFP_SWEEP_FAST 5'h1b
// Last index of the roll, real-time and extended real-time bands, slow to fast
`define ACQFP_SWEEP_ROLL_END 5'h08
`define ACQFP_SWEEP_RT_END 5'h0f
`define ACQFP_SWEEP_ERD_END 5'h16
// Reset values
`define ACQFP_SWEEP_RST 5'h0a
`define ACQFP_CTRL_RST 1'b0
// Record lengths and points per trigger
`define ACQFP_REC_FULL 11'h400
`define ACQFP_REC_ERD 11'h334
`define ACQFP_ERD_PPD 8'h50
`define ACQFP_PPT_50NS 11'h00a
`define ACQFP_PPT_100NS 11'h014
`define ACQFP_PPT_200NS 11'h028
`define ACQFP_PPT_500NS 11'h064
`define ACQFP_PPT_1US 11'h0c8
`endif

// *** rtl/acqfp_top.sv ***
/*
 Acquire-mode front panel control: acquisition mode, freeze, shift prefix,
 sweep selector and digitizing mode, with an AHB-Lite register slave.
 Assumes raw key and detent levels from the panel, asynchronous to I_CLOCK,
 and a single AHB-Lite master issuing single word transfers.
 // Function
 // - Exactly one of four acquisition modes is active; its key lights.
 // - Channel 1 mode digitizes input 1 to memory 1, cursor to 1, disp2 off.
 // - Dual mode digitizes both inputs to both memories, both displays on.
 // - Sum mode digitizes input sum to memory 1, cursor to 1, disp2 off.
 // - Channel 2 mode digitizes input 2 to memory 2 unless frozen, disp1 off.
 // - Freeze stops digitizing and blocks writes to both memories at once.
 // - Freeze ends on second press or averaged, envelope or hold-next.
 // - Shift arms a blinking prefix; next alternate key runs its alternate.
 // - Armed shift plus plain key clears shift and runs the normal function.
 // - Shift pressed again while armed cancels it with no other action.
 // - Sweep selector steps 1-2-5 from 20 s/div to 50 ns/div.
 // - One step slower than 20 s/div selects external sample clocking.
 // - Steps beyond either end are ignored; setting stays at end value.
 // - 1 us to 50 ns uses equivalent time, 1024 points, many triggers.
 // - 200 us to 2 us uses extended real time, 80 pts/div, 820 points.
 // - Extended real time uses interlaced differential sampling.
 // - 50 ms to 500 us, roll and external clock fill 1024 points.
 // - Sequential modes fill the whole memory on one hold-next trigger.
 // - Roll and external clock need no trigger except to end hold-next.
*/
`timescale 1ns/100ps
`include "acqfp_regs.svh"
module acqfp_top #(
   parameter int BLINK_BITS = 24
) (
   input wire logic I_CLOCK,
   input wire logic I_NRST,
   input wire logic [13:0] I_KEYS,
   input wire logic I_TRIGGER,
   input wire logic I_HSEL,
   input wire logic [11:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   output logic [3:0] O_MODE_LAMPS,
   output logic O_FREEZE_LAMP,
   output logic O_SHIFT_LAMP,
   output logic O_CURSOR_WAVEFORM_SELECT,
   output acqfp_pkg::acqfp_path_t O_PATH,
   output acqfp_pkg::acqfp_dig_t O_DIG_MODE,
   output logic O_EXTERNAL_SAMPLE_CLOCKING,
   output logic O_INTERLACED,
   output logic O_NEED_TRIGGER,
   output logic [10:0] O_RECORD_LEN,
   output logic [10:0] O_POINTS_PER_TRIGGER,
   output logic [4:0] O_SWEEP_INDEX
);
   logic [13:0] s1_q, s2_q, s3_q, lvl_q;
   acqfp_pkg::acqfp_keys_t k;
   acqfp_pkg::acqfp_mode_t mode_q;
   logic frz_q, shift_q, csw_q, inv_q, hold_next_q, fill_q;
   logic [4:0] sweep_q;
   logic [BLINK_BITS-1:0] blink_q;
   logic esc_k;
   acqfp_pkg::acqfp_dig_t dig;
   logic ph_act_q, ph_wr_q;
   logic [11:0] ph_addr_q;

   // Three-stage sync; only stages 2 and 3 feed the edge test
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         s1_q <= 14'h0000;
         s2_q <= 14'h0000;
         s3_q <= 14'h0000;
      end else begin
         s1_q <= I_KEYS;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Settled level: a change counts only once stages 2 and 3 agree
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         lvl_q <= 14'h0000;
      end else begin
         lvl_q <= ((s2_q ^ s3_q) & lvl_q) | (~(s2_q ^ s3_q) & s3_q);
      end
   end

   // Agreed rise gives a single-cycle press pulse; a one-stage glitch is lost
   assign k = acqfp_pkg::acqfp_keys_t'(s2_q & s3_q & ~lvl_q);

   // Acquire-type keys that release freeze: averaged, envelope, envelope/acquire, hold-next
   assign esc_k = k.avg_n | k.env | k.envelope_n_acquire | k.hold_next;

   // Acquisition mode: one of four, newest press wins
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         mode_q <= acqfp_pkg::ACQFP_CH1;
      end else if (k.ch1) begin
         mode_q <= acqfp_pkg::ACQFP_CH1;
      end else if (k.ch2) begin
         mode_q <= acqfp_pkg::ACQFP_CH2;
      end else if (k.both) begin
         mode_q <= acqfp_pkg::ACQFP_BOTH;
      end else if (k.add) begin
         mode_q <= acqfp_pkg::ACQFP_ADD;
      end
   end

   // Cursor select follows the mode only when it points at a dropped channel
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         csw_q <= 1'b0;
      end else if ((k.ch1 || k.add) && csw_q) begin
         csw_q <= 1'b0;
      end else if (k.ch2 && !csw_q) begin
         csw_q <= 1'b1;
      end
   end

   // Freeze toggles; acquire-type keys release it
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         frz_q <= 1'b0;
      end else if (esc_k) begin
         frz_q <= 1'b0;
      end else if (k.freeze) begin
         frz_q <= ~frz_q;
      end else if (fill_q && hold_next_q && I_TRIGGER) begin
         frz_q <= 1'b1;
      end
   end

   // Hold-next pending until the next trigger or a freeze key press
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         hold_next_q <= 1'b0;
         fill_q <= 1'b0;
      end else begin
         if (k.hold_next) begin
            hold_next_q <= 1'b1;
         end else if (I_TRIGGER || k.freeze) begin
            hold_next_q <= 1'b0;
         end
         // Sequential modes complete on one trigger; random mode does not
         fill_q <= (dig != acqfp_pkg::ACQFP_DIG_EQT);
      end
   end

   // Shift prefix: cleared by any following key except the sweep detents, toggled by itself
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         shift_q <= 1'b0;
      end else if (k.shift) begin
         shift_q <= ~shift_q;
      end else if (k.alt_key || k.plain_key || k.ch1 || k.ch2
                   || k.both || k.add || k.freeze || esc_k) begin
         shift_q <= 1'b0;
      end
   end

   // Blink divider for the armed shift lamp
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         blink_q <= '0;
      end else begin
         blink_q <= blink_q + 1'b1;
      end
   end

   // Sweep index walks with clamps at both ends
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         sweep_q <= `ACQFP_SWEEP_RST;
      end else if (k.cw && !k.ccw && sweep_q != `ACQFP_SWEEP_FAST) begin
         sweep_q <= sweep_q + 5'h01;
      end else if (k.ccw && !k.cw && sweep_q != `ACQFP_SWEEP_EXT) begin
         sweep_q <= sweep_q - 5'h01;
      end
   end

   // Digitizing band from sweep index
   always_comb begin
      if (sweep_q <= `ACQFP_SWEEP_ROLL_END) begin
         dig = acqfp_pkg::ACQFP_DIG_ROLL;
      end else if (sweep_q <= `ACQFP_SWEEP_RT_END) begin
         dig = acqfp_pkg::ACQFP_DIG_RT;
      end else if (sweep_q <= `ACQFP_SWEEP_ERD_END) begin
         dig = acqfp_pkg::ACQFP_DIG_ERD;
      end else begin
         dig = acqfp_pkg::ACQFP_DIG_EQT;
      end
   end

   // Digitizing outputs registered
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         O_DIG_MODE <= acqfp_pkg::ACQFP_DIG_ROLL;
         O_EXTERNAL_SAMPLE_CLOCKING <= 1'b0;
         O_INTERLACED <= 1'b0;
         O_NEED_TRIGGER <= 1'b0;
         O_RECORD_LEN <= `ACQFP_REC_FULL;
         O_POINTS_PER_TRIGGER <= `ACQFP_REC_FULL;
         O_SWEEP_INDEX <= `ACQFP_SWEEP_RST;
      end else begin
         O_DIG_MODE <= dig;
         O_SWEEP_INDEX <= sweep_q;
         O_EXTERNAL_SAMPLE_CLOCKING <= (sweep_q == `ACQFP_SWEEP_EXT);
         O_INTERLACED <= (dig == acqfp_pkg::ACQFP_DIG_ERD);
         // Roll needs a trigger only to end a pending hold-next
         O_NEED_TRIGGER <= (dig != acqfp_pkg::ACQFP_DIG_ROLL)
                           || hold_next_q;
         O_RECORD_LEN <= (dig == acqfp_pkg::ACQFP_DIG_ERD) ?
                         `ACQFP_REC_ERD : `ACQFP_REC_FULL;
         case (sweep_q)
            `ACQFP_SWEEP_FAST: O_POINTS_PER_TRIGGER <= `ACQFP_PPT_50NS;
            `ACQFP_SWEEP_FAST - 5'h01:
               O_POINTS_PER_TRIGGER <= `ACQFP_PPT_100NS;
            `ACQFP_SWEEP_FAST - 5'h02:
               O_POINTS_PER_TRIGGER <= `ACQFP_PPT_200NS;
            `ACQFP_SWEEP_FAST - 5'h03:
               O_POINTS_PER_TRIGGER <= `ACQFP_PPT_500NS;
            `ACQFP_SWEEP_FAST - 5'h04:
               O_POINTS_PER_TRIGGER <= `ACQFP_PPT_1US;
            default: O_POINTS_PER_TRIGGER <=
               (dig == acqfp_pkg::ACQFP_DIG_ERD) ?
               `ACQFP_REC_ERD : `ACQFP_REC_FULL;
         endcase
      end
   end

   // Path enables; freeze gates digitizing and writes in the same cycle
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         O_PATH <= '0;
         O_MODE_LAMPS <= 4'h1;
         O_FREEZE_LAMP <= 1'b0;
         O_SHIFT_LAMP <= 1'b0;
         O_CURSOR_WAVEFORM_SELECT <= 1'b0;
      end else begin
         O_PATH.dig1 <= !frz_q && (mode_q != acqfp_pkg::ACQFP_CH2);
         O_PATH.dig2 <= !frz_q && (mode_q == acqfp_pkg::ACQFP_CH2
                        || mode_q == acqfp_pkg::ACQFP_BOTH);
         O_PATH.sum <= (mode_q == acqfp_pkg::ACQFP_ADD);
         O_PATH.inv2 <= inv_q;
         O_PATH.wr1 <= !frz_q && (mode_q != acqfp_pkg::ACQFP_CH2);
         O_PATH.wr2 <= !frz_q && (mode_q == acqfp_pkg::ACQFP_CH2
                       || mode_q == acqfp_pkg::ACQFP_BOTH);
         O_PATH.disp1 <= (mode_q != acqfp_pkg::ACQFP_CH2);
         O_PATH.disp2 <= (mode_q == acqfp_pkg::ACQFP_CH2
                         || mode_q == acqfp_pkg::ACQFP_BOTH);
         O_MODE_LAMPS <= 4'h1 << mode_q;
         O_FREEZE_LAMP <= frz_q;
         O_SHIFT_LAMP <= shift_q && blink_q[BLINK_BITS-1];
         O_CURSOR_WAVEFORM_SELECT <= csw_q;
      end
   end

   // AHB-Lite address phase capture; zero wait states
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         ph_act_q <= 1'b0;
         ph_wr_q <= 1'b0;
         ph_addr_q <= 12'h000;
      end else if (I_HREADY) begin
         ph_act_q <= I_HSEL && I_HTRANS[1];
         ph_wr_q <= I_HWRITE;
         ph_addr_q <= I_HADDR;
      end
   end

   // Control register write: channel-2 invert
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         inv_q <= `ACQFP_CTRL_RST;
      end else if (ph_act_q && ph_wr_q && ph_addr_q == `ACQFP_CTRL_OFS) begin
         inv_q <= I_HWDATA[`ACQFP_CTRL_INV_BIT];
      end
   end

   // Read data for the following data phase; unmapped reads zero
   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         O_HRDATA <= 32'h0000_0000;
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
      end else begin
         O_HREADYOUT <= 1'b1;
         O_HRESP <= 1'b0;
         if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
            case (I_HADDR)
               `ACQFP_CTRL_OFS: O_HRDATA <= {31'h0, inv_q};
               `ACQFP_STAT_OFS: O_HRDATA <= {25'h0, dig, csw_q, shift_q,
                                             frz_q, mode_q};
               `ACQFP_SWEEP_OFS: O_HRDATA <= {27'h0, sweep_q};
               default: O_HRDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Checks
   property p_mode_onehot;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      $onehot(O_MODE_LAMPS);
   endproperty
   a_mode_onehot: assert property (p_mode_onehot)
      else $error("mode lamps not one-hot");

   property p_ch1_press;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      k.ch1 && !k.ch2 |-> ##2 (O_MODE_LAMPS == 4'h1) && !O_PATH.disp2
         && !O_CURSOR_WAVEFORM_SELECT;
   endproperty
   a_ch1_press: assert property (p_ch1_press)
      else $error("channel 1 mode not applied");

   property p_both;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      mode_q == acqfp_pkg::ACQFP_BOTH && !frz_q |=> O_PATH.dig1
         && O_PATH.dig2 && O_PATH.disp1 && O_PATH.disp2;
   endproperty
   a_both: assert property (p_both)
      else $error("dual mode paths wrong");

   property p_add;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      mode_q == acqfp_pkg::ACQFP_ADD |=> O_PATH.sum && !O_PATH.disp2;
   endproperty
   a_add: assert property (p_add)
      else $error("sum mode paths wrong");

   property p_ch2;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      k.ch2 && !k.ch1 && !csw_q |-> ##2 O_CURSOR_WAVEFORM_SELECT
         && !O_PATH.disp1;
   endproperty
   a_ch2: assert property (p_ch2)
      else $error("channel 2 mode not applied");

   property p_freeze;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      frz_q |=> !O_PATH.wr1 && !O_PATH.wr2 && !O_PATH.dig1;
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("write while frozen");

   property p_unfreeze;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      esc_k |=> !frz_q ##1 !O_FREEZE_LAMP;
   endproperty
   a_unfreeze: assert property (p_unfreeze)
      else $error("freeze not released");

   property p_shift_cancel;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      shift_q && k.shift |=> !shift_q && $stable(mode_q);
   endproperty
   a_shift_cancel: assert property (p_shift_cancel)
      else $error("shift cancel wrong");

   property p_shift_plain;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      shift_q && k.plain_key && !k.shift |=> !shift_q;
   endproperty
   a_shift_plain: assert property (p_shift_plain)
      else $error("shift not cleared");

   property p_clamp;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      sweep_q == `ACQFP_SWEEP_EXT && k.ccw |=> sweep_q == `ACQFP_SWEEP_EXT;
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("sweep passed external end");

   property p_erd;
      @(posedge I_CLOCK) disable iff (!I_NRST)
      dig == acqfp_pkg::ACQFP_DIG_ERD |=> O_INTERLACED
         && O_RECORD_LEN == `ACQFP_REC_ERD;
   endproperty
   a_erd: assert property (p_erd)
      else $error("extended real time outputs wrong");
endmodule

// *** tb/acqfp_panel.sv ***
/*
 Front-panel operator model: keys and sweep detents as raw levels.
 Assumes the bench calls press() from one process at a time.
*/
`timescale 1ns/100ps
module acqfp_panel (
   input wire logic i_clock,
   output logic [13:0] o_keys
);
   // Keys rest released; a key has no floating state
   initial begin
      o_keys = 14'h0000;
   end
   // One press held past the synchroniser, then a quiet gap
   task automatic press(input int k);
      @(posedge i_clock);
      o_keys[k] <= 1'b1;
      repeat (3) @(posedge i_clock);
      o_keys[k] <= 1'b0;
      repeat (9) @(posedge i_clock);
      #1;
   endtask
endmodule

// *** tb/test_acquire_mode_front_panel_control.sv ***
/*
 Self-checking bench of the acquire-mode front panel control block.
 Assumes the design answers every bus transfer with zero wait states.
*/
`timescale 1ns/100ps
module test_acquire_mode_front_panel_control;
   localparam int K_CH1 = 13, K_CH2 = 12, K_BOTH = 11, K_ADD = 10;
   localparam int K_FRZ = 9, K_SHIFT = 8, K_AVG = 7, K_ENV = 6;
   localparam int K_ENVN = 5, K_HOLD = 4, K_ALT = 3, K_PLAIN = 2;
   localparam int K_CW = 1, K_CCW = 0;
   logic clk = 1'b0, nrst = 1'b0, trig = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, frz, shl, cursor_waveform_select, ext, intl, ntrig;
   logic [13:0] keys;
   logic [3:0] lamps;
   logic [4:0] idx;
   logic [10:0] rlen, ppt;
   acqfp_pkg::acqfp_path_t path;
   acqfp_pkg::acqfp_dig_t dig;
   int failures = 0, n_compared = 0;
   // Free-running 100 MHz clock
   always #5 clk = ~clk;
   acqfp_panel panel (.i_clock(clk), .o_keys(keys));
   acqfp_top #(.BLINK_BITS(3)) uut (.I_CLOCK(clk), .I_NRST(nrst), .I_KEYS(keys),
      .I_TRIGGER(trig), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
      .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
      .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
      .O_HRESP(hresp), .O_MODE_LAMPS(lamps), .O_FREEZE_LAMP(frz),
      .O_SHIFT_LAMP(shl), .O_CURSOR_WAVEFORM_SELECT(cursor_waveform_select), .O_PATH(path),
      .O_DIG_MODE(dig), .O_EXTERNAL_SAMPLE_CLOCKING(ext),
      .O_INTERLACED(intl), .O_NEED_TRIGGER(ntrig), .O_RECORD_LEN(rlen),
      .O_POINTS_PER_TRIGGER(ppt), .O_SWEEP_INDEX(idx));
   task automatic finish_test();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for hready; a stuck slave ends the run
   task automatic wait_ready();
      int n;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (hreadyout === 1'b1) break;
      end
      if (n == 16) begin
         failures++;
         finish_test();
      end
   endtask
   // One single-word transfer, address phase then data phase
   task automatic ahb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      r = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic pulse_trigger();
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic t_reset();
      chk(lamps, 4'h1);
      chk({frz, cursor_waveform_select, ext, hresp}, 4'h0);
      chk(idx, 5'h0a);
      ahb(1'b0, 12'h004, 32'h0, rd);
      chk(rd, 32'h0000_0020);
      ahb(1'b0, 12'h008, 32'h0, rd);
      chk(rd, 32'h0000_000a);
   endtask
   // Mode keys in an order that moves the cursor both ways
   task automatic t_modes();
      int k[5] = '{K_CH2, K_ADD, K_BOTH, K_CH2, K_CH1};
      logic [3:0] l[5] = '{4'h2, 4'h8, 4'h4, 4'h2, 4'h1};
      logic c[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      logic [7:0] m[5] = '{8'h46, 8'h29, 8'hcf, 8'h46, 8'he9};
      logic [7:0] e[5] = '{8'h44, 8'h28, 8'hcf, 8'h44, 8'h88};
      for (int i = 0; i < 5; i++) begin
         panel.press(k[i]);
         chk(lamps, l[i]);
         chk(cursor_waveform_select, c[i]);
         chk(path & m[i], e[i]);
      end
   endtask
   // Channel-2 invert reaches the path; unmapped reads as zero
   task automatic t_regs();
      panel.press(K_ADD);
      ahb(1'b1, 12'h000, 32'h1, rd);
      repeat (2) @(posedge clk);
      #1;
      chk(path.inv2, 1'b1);
      ahb(1'b0, 12'h000, 32'h0, rd);
      chk(rd, 32'h1);
      ahb(1'b0, 12'h00c, 32'h0, rd);
      chk(rd, 32'h0);
      panel.press(K_CH2);
   endtask
   task automatic t_freeze();
      int rel[4] = '{K_AVG, K_ENV, K_ENVN, K_FRZ};
      for (int i = 0; i < 4; i++) begin
         panel.press(K_FRZ);
         chk(frz, 1'b1);
         chk(path & 8'h4c, 8'h00);
         chk(lamps, 4'h2);
         panel.press(rel[i]);
         chk(frz, 1'b0);
         chk(path & 8'h44, 8'h44);
      end
      panel.press(K_FRZ);
      panel.press(K_HOLD);
      chk({frz, ntrig}, 2'b01);
      pulse_trigger();
      chk(frz, 1'b1);
      panel.press(K_FRZ);
      chk(frz, 1'b0);
   endtask
   task automatic t_shift();
      int nx[3] = '{K_ALT, K_PLAIN, K_SHIFT};
      int n;
      for (int i = 0; i < 3; i++) begin
         panel.press(K_SHIFT);
         ahb(1'b0, 12'h004, 32'h0, rd);
         chk(rd[3], 1'b1);
         // Armed lamp blinks: lit half of one 8-cycle blink period
         n = 0;
         repeat (8) begin
            @(posedge clk);
            #1;
            if (shl === 1'b1) n++;
         end
         chk(n, 4);
         panel.press(nx[i]);
         ahb(1'b0, 12'h004, 32'h0, rd);
         chk(rd[3], 1'b0);
         chk(rd[1:0], 2'h1);
      end
      panel.press(K_SHIFT);
      panel.press(K_BOTH);
      ahb(1'b0, 12'h004, 32'h0, rd);
      chk(rd[3:0], 4'h2);
      chk(shl, 1'b0);
   endtask
   // Expected digitizing outputs for one selector index
   task automatic chk_band(input int i);
      logic [10:0] p[5] = '{11'h0c8, 11'h064, 11'h028, 11'h014, 11'h00a};
      chk(idx, i[4:0]);
      chk(ext, i == 0);
      chk(dig, i < 9 ? 2'h0 : i < 16 ? 2'h1 : i < 23 ? 2'h2 : 2'h3);
      chk(rlen, (i > 15 && i < 23) ? 11'h334 : 11'h400);
      chk(intl, i > 15 && i < 23);
      chk(ntrig, i > 8);
      if (i > 22) chk(ppt, p[i - 23]);
      else chk(ppt, (i > 15) ? 11'h334 : 11'h400);
   endtask
   task automatic t_sweep();
      for (int i = 0; i < 11; i++) panel.press(K_CCW);
      chk_band(0);
      panel.press(K_HOLD);
      chk(ntrig, 1'b1);
      pulse_trigger();
      chk({frz, ntrig}, 2'b10);
      panel.press(K_FRZ);
      for (int i = 1; i < 28; i++) begin
         panel.press(K_CW);
         chk_band(i);
      end
      panel.press(K_CW);
      chk_band(27);
   endtask
   // Watchdog against a hang anywhere in the sequence
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      t_reset();
      t_modes();
      t_regs();
      t_freeze();
      t_shift();
      t_sweep();
      finish_test();
   end
endmodule
